// File: design/sfpx_pkg.sv
// constants and types shared by the single-precision simd datapath
package sfpx_pkg;
	typedef enum logic [2:0] {
		OP_PACKED_SUB = 3'h0,
		OP_SCALAR_SUB = 3'h1,
		OP_UNORD_CMP  = 3'h2,
		OP_ORD_CMP    = 3'h3,
		OP_HIGH_ILV   = 3'h4,
		OP_LOW_ILV    = 3'h5,
		OP_XOR        = 3'h6
	} sfpx_op_e;

	typedef enum logic [1:0] {
		MODE_REAL = 2'h0,
		MODE_PROT = 2'h1,
		MODE_V86  = 2'h2
	} sfpx_mode_e;

	// fault kinds; real-mode limit violation reports as FLT_GP (vector 13)
	typedef enum logic [3:0] {
		FLT_NONE    = 4'h0,
		FLT_UD      = 4'h1,
		FLT_NM      = 4'h2,
		FLT_GP      = 4'h3,
		FLT_SS      = 4'h4,
		FLT_PAGE    = 4'h5,
		FLT_AC      = 4'h6,
		FLT_XM      = 4'h7,
		FLT_NAT     = 4'h8,
		FLT_HOSTMEM = 4'h9
	} sfpx_fault_e;

	// register offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// control register fields
	localparam int CTL_COPROC_ABSENT = 0;
	localparam int CTL_TASK_SWITCHED = 1;
	localparam int CTL_ALIGN_MASK    = 2;
	localparam int CTL_FAULT_ENABLE  = 3;
	localparam int CTL_STATE_ENABLE  = 9;
	localparam int CTL_MASK_LSB      = 16;
	localparam int CTL_FEATURE       = 25;
	localparam logic [31:0] CTRL_RST = 32'h021f0000;
	localparam logic [31:0] CTRL_WMASK = 32'h021f020f;

	// status register fields
	localparam int STS_FAULT_LSB = 8;

	// numeric condition bit order
	localparam int FL_INV = 4;
	localparam int FL_DEN = 3;
	localparam int FL_OVF = 2;
	localparam int FL_UND = 1;
	localparam int FL_INE = 0;

	localparam logic [31:0] DEFAULT_NAN = 32'hffc00000;
	localparam logic [31:0] QUIET_BIT   = 32'h00400000;
	localparam logic [32:0] REAL_LIMIT  = 33'h00000ffff;
	localparam logic [32:0] SPAN_FULL   = 33'h00000000f;
	localparam logic [32:0] SPAN_LANE   = 33'h000000003;
endpackage

// File: design/sfpx_datapath.sv
// single-precision simd subtract, compare, interleave and xor with fault checks
`timescale 1ns/1ps

// Overview of operation
// [RL1] packed subtract on all four lanes
// [RL2] scalar subtract lowest lane, no 16-byte check
// [RL3] packed forms fault on misaligned 128-bit operand
// [RL4] subtracts flag five conditions; compares invalid and denormal only; others none
// [RL5] compare sets zero, parity, carry flags
// [RL6] compare clears overflow, sign, adjust flags
// [RL7] any not-a-number gives unordered result
// [RL8] invalid: signalling only, ordered: any nan
// [RL9] unmasked compare condition leaves flags unchanged
// [RL10] unmasked condition: simd fault or undefined
// [RL11] state enable or feature off: undefined
// [RL12] coprocessor absent undefined; task switched unavailable
// [RL13] scalar alignment check needs mask, flag, level3
// [RL14] real mode 64k limit; v86 adds pages
// [RL15] protected: segment, stack and page faults
// [RL16] high interleave takes top lane of each operand; lower half kept from destination
// [RL17] low interleave takes lower two lanes
// [RL18] partial fetch still checked as full operand
// [RL19] xor writes full 128-bit exclusive-or
// [RL20] software avoids repeat and size prefixes
// [RL21] host mode: token and memory faults
// [RL22] faults decided before any write
module sfpx_datapath
	import sfpx_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [3:0]   regAddr,
	input  wire logic [31:0]  regWdata,
	input  wire logic         regWrite,
	input  wire logic         regRead,
	output logic      [31:0]  regRdata,
	input  wire logic         opValid,
	input  wire sfpx_op_e     opCode,
	input  wire logic [127:0] dstIn,
	input  wire logic [127:0] srcIn,
	input  wire logic         srcIsMem,
	input  wire logic [31:0]  memAddr,
	input  wire sfpx_mode_e   execMode,
	input  wire logic [1:0]   curPrivLevel,
	input  wire logic         alignCheckFlag,
	input  wire logic         segAddrBad,
	input  wire logic         stackAddrBad,
	input  wire logic         pageMissing,
	input  wire logic         hostEnv,
	input  wire logic         notAThingToken,
	input  wire logic [5:0]   hostMemFault,
	output logic              resValid,
	output logic      [127:0] resData,
	output logic              flagsWrite,
	output logic      [5:0]   intFlags,
	output logic              faultValid,
	output sfpx_fault_e       faultKind
);
	// =========================================================
	// floating-point helpers
	function automatic logic isNan(input logic [31:0] v);
		return (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
	endfunction

	function automatic logic isSnan(input logic [31:0] v);
		return isNan(v) && !v[22];
	endfunction

	function automatic logic isDen(input logic [31:0] v);
		return (v[30:23] == 8'h00) && (v[22:0] != 23'h0);
	endfunction

	// returns {conditions[4:0], result[31:0]} of a - b, nearest-even
	function automatic logic [36:0] fpSub(input logic [31:0] a, input logic [31:0] b);
		logic        sA;
		logic        sB;
		logic        sR;
		logic        bigA;
		logic        stk;
		logic [7:0]  eBig;
		logic [7:0]  eSml;
		logic [26:0] mBig;
		logic [26:0] mSml;
		logic [27:0] sum;
		logic [9:0]  ex;
		logic [7:0]  shf;
		logic [24:0] rnd;
		logic [4:0]  fl;
		logic [31:0] res;
		sA = a[31];
		sB = ~b[31];
		fl = 5'h00;
		res = 32'h0;
		sum = 28'h0;
		fl[FL_DEN] = isDen(a) || isDen(b);
		if (isNan(a) || isNan(b)) begin
			fl[FL_INV] = isSnan(a) || isSnan(b);
			res = isNan(a) ? (a | QUIET_BIT) : (b | QUIET_BIT);
		end else if (a[30:23] == 8'hff && b[30:23] == 8'hff && sA != sB) begin
			fl[FL_INV] = 1'b1;
			res = DEFAULT_NAN;
		end else if (a[30:23] == 8'hff) begin
			res = a;
		end else if (b[30:23] == 8'hff) begin
			res = {sB, b[30:0]};
		end else begin
			bigA = a[30:0] >= b[30:0];
			sR = bigA ? sA : sB;
			eBig = bigA ? a[30:23] : b[30:23];
			eSml = bigA ? b[30:23] : a[30:23];
			mBig = {eBig != 8'h00, bigA ? a[22:0] : b[22:0], 3'b000};
			mSml = {eSml != 8'h00, bigA ? b[22:0] : a[22:0], 3'b000};
			if (eBig == 8'h00) eBig = 8'h01;
			if (eSml == 8'h00) eSml = 8'h01;
			shf = eBig - eSml;
			stk = 1'b0;
			for (int i = 0; i < 27; i++) begin
				if (shf != 8'h00) begin
					stk = stk | mSml[0];
					mSml = {1'b0, mSml[26:1]};
					shf = shf - 8'h01;
				end
			end
			mSml[0] = mSml[0] | stk;
			sum = (sA == sB) ? ({1'b0, mBig} + {1'b0, mSml}) : ({1'b0, mBig} - {1'b0, mSml});
			ex = {2'b00, eBig};
			if (sum == 28'h0) begin
				res = {sA & sB, 31'h0};
			end else begin
				if (sum[27]) begin
					sum = {1'b0, sum[27:2], sum[1] | sum[0]};
					ex = ex + 10'h001;
				end
				for (int i = 0; i < 26; i++) begin
					if (!sum[26] && ex > 10'h001) begin
						sum = {sum[26:0], 1'b0};
						ex = ex - 10'h001;
					end
				end
				if (!sum[26]) ex = 10'h000;
				fl[FL_INE] = |sum[2:0];
				rnd = {1'b0, sum[26:3]} + {24'h0, sum[2] & (sum[1] | sum[0] | sum[3])};
				if (rnd[24]) begin
					rnd = {1'b0, rnd[24:1]};
					ex = ex + 10'h001;
				end else if (ex == 10'h000 && rnd[23]) begin
					ex = 10'h001;
				end
				fl[FL_UND] = (ex == 10'h000);
				if (ex >= 10'h0ff) begin
					fl[FL_OVF] = 1'b1;
					fl[FL_INE] = 1'b1;
					res = {sR, 8'hff, 23'h0};
				end else begin
					res = {sR, ex[7:0], rnd[22:0]};
				end
			end
		end
		return {fl, res};
	endfunction

	// returns {invalid, denormal, zero, parity, carry}
	function automatic logic [4:0] fpCmp(input logic [31:0] a, input logic [31:0] b, input logic ordered);
		logic unord;
		logic inv;
		logic aLt;
		unord = isNan(a) || isNan(b);
		// [RL8] invalid depends on compare kind
		inv = ordered ? unord : (isSnan(a) || isSnan(b));
		if (a[31] != b[31]) aLt = a[31];
		else aLt = a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
		if (unord) return {inv, isDen(a) || isDen(b), 3'b111};
		else if (a == b || {a[30:0], b[30:0]} == 62'h0) return {inv, isDen(a) || isDen(b), 3'b100};
		else return {inv, isDen(a) || isDen(b), 2'b00, aLt};
	endfunction

	// =========================================================
	// registers
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [4:0]  sticky_reg;
	logic [4:0]  sticky_next;
	logic [3:0]  lastFault_reg;

	wire coprocAbsent = ctrl_reg[CTL_COPROC_ABSENT];
	wire taskSwitched = ctrl_reg[CTL_TASK_SWITCHED];
	wire alignMask    = ctrl_reg[CTL_ALIGN_MASK];
	wire faultEnable  = ctrl_reg[CTL_FAULT_ENABLE];
	wire stateEnable  = ctrl_reg[CTL_STATE_ENABLE];
	wire featureFlag  = ctrl_reg[CTL_FEATURE];
	wire [4:0] condMask = ctrl_reg[CTL_MASK_LSB +: 5];

	// =========================================================
	// decode
	wire isPSub  = opCode == OP_PACKED_SUB;
	wire isSSub  = opCode == OP_SCALAR_SUB;
	wire isCmp   = opCode == OP_UNORD_CMP || opCode == OP_ORD_CMP;
	wire isFull  = isPSub || opCode == OP_HIGH_ILV || opCode == OP_LOW_ILV || opCode == OP_XOR;
	wire isMem   = opValid && srcIsMem;
	wire [32:0] lastByte = {1'b0, memAddr} + (isFull ? SPAN_FULL : SPAN_LANE);
	wire realOut = lastByte > REAL_LIMIT;
	wire misAlign16 = memAddr[3:0] != 4'h0;
	wire misAlignLane = memAddr[1:0] != 2'b00;
	wire pagingOn = execMode != MODE_REAL;

	// =========================================================
	// arithmetic lanes
	logic [36:0] subLane [4];
	logic [127:0] subRes;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			subLane[i] = fpSub(dstIn[32*i +: 32], srcIn[32*i +: 32]);
			subRes[32*i +: 32] = subLane[i][31:0];
		end
	end
	wire [4:0] cmpOut = fpCmp(dstIn[31:0], srcIn[31:0], opCode == OP_ORD_CMP);

	// [RL4] five conditions for subtracts only
	wire [4:0] condRaw = isPSub ? (subLane[0][36:32] | subLane[1][36:32] | subLane[2][36:32] | subLane[3][36:32]) :
		isSSub ? subLane[0][36:32] : isCmp ? {cmpOut[4:3], 3'b000} : 5'h00;
	wire condUnmasked = |(condRaw & ~condMask);

	// =========================================================
	// fault priority, all settled before any write
	sfpx_fault_e faultNow;
	always_comb begin
		faultNow = FLT_NONE;
		// [RL11] [RL12] enables and feature
		if (coprocAbsent || !stateEnable || !featureFlag) faultNow = FLT_UD;
		// [RL12] task switched
		else if (taskSwitched) faultNow = FLT_NM;
		// [RL21] token consumption
		else if (hostEnv && notAThingToken) faultNow = FLT_NAT;
		// [RL14] real and v86 limit
		else if (isMem && execMode != MODE_PROT && realOut) faultNow = FLT_GP;
		// [RL15] segment checks
		else if (isMem && execMode == MODE_PROT && segAddrBad) faultNow = FLT_GP;
		else if (isMem && execMode == MODE_PROT && stackAddrBad) faultNow = FLT_SS;
		// [RL3] [RL18] full operand alignment
		else if (isMem && isFull && misAlign16) faultNow = FLT_GP;
		// [RL14] [RL15] page faults
		else if (isMem && pagingOn && pageMissing) faultNow = FLT_PAGE;
		// [RL2] [RL13] scalar alignment check
		else if (isMem && !isFull && misAlignLane && alignMask && alignCheckFlag && curPrivLevel == 2'h3)
			faultNow = FLT_AC;
		// [RL21] host memory faults
		else if (isMem && hostEnv && hostMemFault != 6'h00) faultNow = FLT_HOSTMEM;
		// [RL9] [RL10] unmasked numeric condition
		else if (condUnmasked) faultNow = faultEnable ? FLT_XM : FLT_UD;
	end

	wire doWrite = opValid && faultNow == FLT_NONE;

	// =========================================================
	// result selection
	logic [127:0] resNext;
	always_comb begin
		case (opCode)
			// [RL1] all four lanes
			OP_PACKED_SUB: resNext = subRes;
			// [RL2] lowest lane only
			OP_SCALAR_SUB: resNext = {dstIn[127:32], subRes[31:0]};
			// [RL16] top lane of each interleaved, lower half from destination
			OP_HIGH_ILV: resNext = {srcIn[127:96], dstIn[127:96], dstIn[63:0]};
			// [RL17] lower lanes interleaved
			OP_LOW_ILV: resNext = {srcIn[63:32], dstIn[63:32], srcIn[31:0], dstIn[31:0]};
			// [RL19] bitwise exclusive-or
			OP_XOR: resNext = dstIn ^ srcIn;
			default: resNext = dstIn;
		endcase
	end

	// =========================================================
	// register port
	assign ctrl_next = (regWrite && regAddr == REG_CTRL) ? (regWdata & CTRL_WMASK) : ctrl_reg;
	// set wins over write-one-to-clear
	assign sticky_next = (sticky_reg & ~((regWrite && regAddr == REG_STATUS) ? regWdata[4:0] : 5'h00)) |
		(doWrite ? condRaw : 5'h00);
	wire [31:0] rdMux = (regAddr == REG_CTRL) ? ctrl_reg :
		(regAddr == REG_STATUS) ? {20'h0, lastFault_reg, 3'h0, sticky_reg} : 32'h0;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_reg      <= CTRL_RST;
			sticky_reg    <= 5'h00;
			lastFault_reg <= 4'h0;
			regRdata      <= 32'h0;
		end else begin
			ctrl_reg   <= ctrl_next;
			sticky_reg <= sticky_next;
			regRdata   <= regRead ? rdMux : 32'h0;
			if (opValid && faultNow != FLT_NONE) lastFault_reg <= faultNow;
		end
	end

	// =========================================================
	// result and flag outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			resValid   <= 1'b0;
			resData    <= 128'h0;
			flagsWrite <= 1'b0;
			intFlags   <= 6'h00;
			faultValid <= 1'b0;
			faultKind  <= FLT_NONE;
		end else begin
			// [RL22] nothing written when faulting
			resValid   <= doWrite && !isCmp;
			flagsWrite <= doWrite && isCmp;
			faultValid <= opValid && faultNow != FLT_NONE;
			faultKind  <= opValid ? faultNow : FLT_NONE;
			if (doWrite && !isCmp) resData <= resNext;
			// [RL5] [RL6] [RL7] {adjust, sign, overflow, zero, parity, carry}
			if (doWrite && isCmp) intFlags <= {3'b000, cmpOut[2:0]};
		end
	end

	// =========================================================
	// checks
	xor_result_a: // [RL19]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		resValid && $past(opCode) == OP_XOR |-> resData == ($past(dstIn) ^ $past(srcIn)))
		else $error("xor result wrong");
	scalar_upper_a: // [RL2]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		resValid && $past(opCode) == OP_SCALAR_SUB |-> resData[127:32] == $past(dstIn[127:32]))
		else $error("scalar subtract touched upper lanes");
	high_ilv_a: // [RL16]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		resValid && $past(opCode) == OP_HIGH_ILV |->
		resData[127:64] == {$past(srcIn[127:96]), $past(dstIn[127:96])})
		else $error("high interleave wrong");
	low_ilv_a: // [RL17]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		resValid && $past(opCode) == OP_LOW_ILV |->
		resData[127:32] == {$past(srcIn[63:32]), $past(dstIn[63:32]), $past(srcIn[31:0])})
		else $error("low interleave wrong");
	cmp_clears_a: // [RL6]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		flagsWrite |-> intFlags[5:3] == 3'b000 && !resValid && !faultValid)
		else $error("compare left upper flags set");
	fault_no_write_a: // [RL22]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		faultValid |-> !resValid && !flagsWrite && $stable(resData) && $stable(intFlags))
		else $error("faulting op wrote state");
	enable_undef_a: // [RL11]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		opValid && (!stateEnable || !featureFlag) |=> faultValid && faultKind == FLT_UD)
		else $error("disabled feature did not fault");
	task_sw_a: // [RL12]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		opValid && taskSwitched && !coprocAbsent && stateEnable && featureFlag |=> faultKind == FLT_NM)
		else $error("task switched not reported");
	packed_align_a: // [RL3]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		opValid && srcIsMem && isFull && misAlign16 |=> faultValid && !resValid)
		else $error("misaligned packed operand accepted");
	cmp_unmasked_a: // [RL9]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		opValid && isCmp && condUnmasked |=> !flagsWrite && $stable(intFlags))
		else $error("flags written under unmasked condition");
	numeric_kind_a: // [RL10]
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		opValid && !srcIsMem && condUnmasked && !coprocAbsent && stateEnable && featureFlag && !taskSwitched &&
		!(hostEnv && notAThingToken) |=> faultValid && faultKind == ($past(faultEnable) ? FLT_XM : FLT_UD))
		else $error("numeric fault kind wrong");
endmodule

// File: sim/sfpx_datapath_tb_top.sv
// self-checking bench for the single-precision simd datapath
`timescale 1ns/1ps
module sfpx_datapath_tb_top
	import sfpx_pkg::*;
;
	typedef struct {
		sfpx_op_e     op;
		logic [127:0] d, s;
		logic         mem;
		logic [31:0]  a;
		sfpx_mode_e   md;
		logic [8:0]   env;
		sfpx_fault_e  f;
		logic [127:0] r, m;
		logic [5:0]   fl;
	} sfpx_row_s;

	// operands: lanes 5,2,1,0.5 and 1,2,-1,0.25
	localparam logic [127:0] D = 128'h40a00000_40000000_3f800000_3f000000;
	localparam logic [127:0] S = 128'h3f800000_40000000_bf800000_3e800000;
	localparam logic [127:0] F = {128{1'h1}};
	localparam logic [127:0] L = 128'hffffffff;
	localparam logic [127:0] H = {64'hffffffffffffffff, 64'h0};
	localparam logic [127:0] Q = 128'h7fc00000;
	localparam logic [127:0] X = D ^ S;
	localparam logic [127:0] HI = {S[127:96], D[127:96], 64'h0};
	localparam logic [127:0] LO = {S[63:32], D[63:32], S[31:0], D[31:0]};
	localparam logic [127:0] PS = 128'h40800000_00000000_40000000_3e800000;

	logic         sys_clk, rst_n, regWrite, regRead, opValid, srcIsMem, alignCheckFlag;
	logic         segAddrBad, stackAddrBad, pageMissing, hostEnv, notAThingToken;
	logic [3:0]   regAddr;
	logic [31:0]  regWdata, memAddr;
	logic [1:0]   curPrivLevel;
	logic [5:0]   hostMemFault;
	sfpx_op_e     opCode;
	sfpx_mode_e   execMode;
	logic [127:0] dstIn, srcIn;
	logic [31:0]  regRdata;
	logic         resValid, flagsWrite, faultValid;
	logic [127:0] resData, lastRes, lastMask;
	logic [5:0]   intFlags, lastFl;
	sfpx_fault_e  faultKind;
	int           nMismatch, samplesChecked;
	sfpx_row_s    rows[23];
	logic [7:0]   cf[4] = '{8'h1b, 8'h17, 8'h1d, 8'h1e};
	logic [31:0]  dv[4] = '{32'h7f7fffff, 32'h00000001, 32'h00800001, 32'h3f800000};
	logic [31:0]  sv[4] = '{32'hff7fffff, 32'h00000000, 32'h00800000, 32'h30800000};
	logic [31:0]  cv[4] = '{32'h021f0201, 32'h021f0202, 32'h001f0200, 32'h021f0000};
	sfpx_fault_e  fv[4] = '{FLT_UD, FLT_NM, FLT_UD, FLT_UD};

	sfpx_datapath sfpx_datapath_i (
		.sys_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .opValid, .opCode,
		.dstIn, .srcIn, .srcIsMem, .memAddr, .execMode, .curPrivLevel, .alignCheckFlag, .segAddrBad,
		.stackAddrBad, .pageMissing, .hostEnv, .notAThingToken, .hostMemFault, .resValid, .resData,
		.flagsWrite, .intFlags, .faultValid, .faultKind
	);

	initial sys_clk = 1'h0;
	always #2.5 sys_clk = ~sys_clk;

	task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
		samplesChecked++;
		if (s !== e) begin
			nMismatch++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic endSim();
		$display("checked %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWrite <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'h0;
		#1;
		chk("regRdata", regRdata & m, e);
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1;
		chk("outputs", {resValid, flagsWrite, faultValid, faultKind, intFlags, regRdata}, 128'h0);
		chk("resData", resData, 128'h0);
		lastRes = 128'h0;
		lastMask = F;
		lastFl = 6'h0;
	endtask

	// env packs {hostMemFault[0],hostEnv,token,page,stack,seg,alignCheckFlag,curPrivLevel}
	task automatic run(input sfpx_row_s t);
		logic cmp;
		logic flt;
		cmp = (t.op == OP_UNORD_CMP) || (t.op == OP_ORD_CMP);
		flt = (t.f != FLT_NONE);
		@(posedge sys_clk);
		opValid <= 1'h1;
		opCode <= t.op;
		dstIn <= t.d;
		srcIn <= t.s;
		srcIsMem <= t.mem;
		memAddr <= t.a;
		execMode <= t.md;
		{hostMemFault[0], hostEnv, notAThingToken, pageMissing, stackAddrBad, segAddrBad, alignCheckFlag,
			curPrivLevel} <= t.env;
		@(posedge sys_clk);
		opValid <= 1'h0;
		#1;
		if (!flt && !cmp) begin
			lastRes = t.r;
			lastMask = t.m;
		end
		if (!flt && cmp)
			lastFl = t.fl;
		chk("faultValid", faultValid, flt);
		chk("faultKind", faultKind, t.f);
		chk("resValid", resValid, !flt && !cmp);
		chk("flagsWrite", flagsWrite, !flt && cmp);
		chk("resData", resData & lastMask, lastRes & lastMask);
		chk("intFlags", intFlags, lastFl);
	endtask

	initial begin
		repeat (4000) @(posedge sys_clk);
		nMismatch++;
		endSim();
	end

	initial begin
		rst_n = 1'h0;
		{regWrite, regRead, opValid, srcIsMem, alignCheckFlag, segAddrBad, stackAddrBad} = '0;
		{pageMissing, hostEnv, notAThingToken, regAddr, regWdata, memAddr, curPrivLevel} = '0;
		{hostMemFault, dstIn, srcIn} = '0;
		opCode = OP_XOR;
		execMode = MODE_PROT;
		nMismatch = 0;
		samplesChecked = 0;
		rows = '{
			'{OP_XOR, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, X, F, 6'h0},
			'{OP_HIGH_ILV, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, HI, H, 6'h0},
			'{OP_LOW_ILV, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, LO, F, 6'h0},
			'{OP_PACKED_SUB, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, PS, F, 6'h0},
			'{OP_SCALAR_SUB, D, S, 1'h1, 32'h8, MODE_PROT, 9'h0, FLT_NONE, 128'h3e800000, L, 6'h0},
			'{OP_UNORD_CMP, S, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h04},
			'{OP_UNORD_CMP, S, D, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h01},
			'{OP_ORD_CMP, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h00},
			'{OP_UNORD_CMP, D, Q, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h07},
			'{OP_PACKED_SUB, D, S, 1'h1, 32'h8, MODE_PROT, 9'h0, FLT_GP, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h4, MODE_PROT, 9'h0, FLT_GP, 128'h0, F, 6'h0},
			'{OP_LOW_ILV, D, S, 1'h1, 32'h18, MODE_PROT, 9'h0, FLT_GP, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'hfff0, MODE_REAL, 9'h0, FLT_NONE, X, F, 6'h0},
			'{OP_HIGH_ILV, D, S, 1'h1, 32'h10000, MODE_REAL, 9'h0, FLT_GP, 128'h0, F, 6'h0},
			'{OP_SCALAR_SUB, D, S, 1'h1, 32'hfffe, MODE_REAL, 9'h0, FLT_GP, 128'h0, F, 6'h0},
			'{OP_SCALAR_SUB, D, S, 1'h1, 32'hfffc, MODE_REAL, 9'h020, FLT_NONE, 128'h3e800000, L, 6'h0},
			'{OP_SCALAR_SUB, D, S, 1'h1, 32'hfffc, MODE_V86, 9'h020, FLT_PAGE, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h10, MODE_PROT, 9'h008, FLT_GP, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h10, MODE_PROT, 9'h010, FLT_SS, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h10, MODE_PROT, 9'h020, FLT_PAGE, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0c0, FLT_NAT, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h10, MODE_PROT, 9'h180, FLT_HOSTMEM, 128'h0, F, 6'h0},
			'{OP_XOR, D, S, 1'h1, 32'h10, MODE_PROT, 9'h100, FLT_NONE, X, F, 6'h0}
		};
		do_reset();
		rd(4'h0, 32'hffffffff, 32'h021f0000);
		rd(4'h4, 32'hffffffff, 32'h0);
		run('{OP_XOR, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_UD, 128'h0, F, 6'h0});
		wr(4'h8, 32'hffffffff);
		rd(4'h8, 32'hffffffff, 32'h0);
		wr(4'h0, 32'hffffffff);
		rd(4'h0, 32'hffffffff, 32'h021f020f);
		wr(4'h0, 32'h021f0200);
		foreach (rows[i])
			run(rows[i]);
		rd(4'h4, 32'h00000f00, 32'h00000900);
		// unmasked invalid, numeric fault delivery on
		wr(4'h0, 32'h020f0208);
		run('{OP_UNORD_CMP, S, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h04});
		run('{OP_UNORD_CMP, S, 128'h7f800001, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_XM, 128'h0, F, 6'h0});
		run('{OP_UNORD_CMP, S, Q, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, 128'h0, F, 6'h07});
		run('{OP_ORD_CMP, S, Q, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_XM, 128'h0, F, 6'h0});
		run('{OP_PACKED_SUB, 128'h7f800000, 128'h7f800000, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_XM,
			128'h0, F, 6'h0});
		wr(4'h0, 32'h020f0200);
		run('{OP_ORD_CMP, S, Q, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_UD, 128'h0, F, 6'h0});
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {8'h02, cf[i], 16'h0208});
			run('{OP_PACKED_SUB, {96'h0, dv[i]}, {96'h0, sv[i]}, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_XM,
				128'h0, F, 6'h0});
		end
		wr(4'h0, 32'h02000208);
		run('{OP_XOR, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE, X, F, 6'h0});
		// masked inexact sets its sticky bit only
		wr(4'h0, 32'h021f0200);
		wr(4'h4, 32'h0000001f);
		run('{OP_SCALAR_SUB, {96'h0, dv[3]}, {96'h0, sv[3]}, 1'h0, 32'h0, MODE_PROT, 9'h0, FLT_NONE,
			128'h3f800000, F, 6'h0});
		rd(4'h4, 32'h0000001f, 32'h00000001);
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, cv[i]);
			run('{OP_XOR, D, S, 1'h0, 32'h0, MODE_PROT, 9'h0, fv[i], 128'h0, F, 6'h0});
		end
		wr(4'h0, 32'h021f0204);
		run('{OP_SCALAR_SUB, D, S, 1'h1, 32'h1, MODE_PROT, 9'h007, FLT_AC, 128'h0, F, 6'h0});
		run('{OP_UNORD_CMP, S, S, 1'h1, 32'h2, MODE_V86, 9'h007, FLT_AC, 128'h0, F, 6'h0});
		run('{OP_SCALAR_SUB, D, S, 1'h1, 32'h1, MODE_PROT, 9'h006, FLT_NONE, 128'h3e800000, L, 6'h0});
		run('{OP_UNORD_CMP, S, S, 1'h1, 32'h2, MODE_PROT, 9'h003, FLT_NONE, 128'h0, F, 6'h04});
		do_reset();
		rd(4'h0, 32'hffffffff, 32'h021f0000);
		endSim();
	end
endmodule
